// ==== verilog/pser_port_status.sv ====
// Port status flags, port state tracking and CPU read access to the report registers
`timescale 1ns/1ps
`default_nettype none

// Function
// - Register access parity error sets its flag, maintenance flag, port goes uninitialized.
// - Shared store error sets its flag, maintenance flag, port goes uninitialized.
// - Status bits 15..8 read zero; CPU writes never change status.
// - Miscellaneous error sets flag, records code, port enters disabled/maintenance.
// - Maintenance timer expiry sets its flag, port enters uninitialized/maintenance.
// - Memory data or nonexistent error sets flag, port disabled or disabled/maintenance.
// - Data structure error sets flag, disables port; queue errors lock queues.
// - Initialization finished sets flag; port rests disabled or disabled/maintenance.
// - Reaching disabled state sets the disable complete flag.
// - Empty message pool sets flag while command processing continues.
// - Inserting into an empty response queue sets the reply ready flag.
// - Fault code register is read-only, meaningful only after listed faults.
// - Fault code: module byte, specific byte on top, structure number low half.
// - Listed faults and buffer memory errors load the failing address register.
// - Address kind depends on fault: virtual, physical, or error specific.
// - Buffer errors overwrite address; stopping faults keep it fixed.
// - Failing address register is read-only, valid only after listed faults.
// - Top status bit marks maintenance fault; port then uninitialized.
// - Enabled interrupts fire per status update; status frozen until release.
// - Status is read-only, readable except during chip initialization.
module pser_port_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // CPU register access
  input wire pser_pkg::pser_cpu_req_s cpu_req,
  output logic [31:0] cpu_rdata,
  output logic cpu_ack,
  // Port engine events and modes
  input wire pser_pkg::pser_event_s ev,
  input wire logic maint_mode,
  input wire logic chip_init,
  // Links to the control registers
  input wire logic status_release,
  input wire logic irq_enable,
  // Results
  output logic status_irq,
  output logic queues_locked,
  output var pser_pkg::pser_state_e port_state
);

  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] pending_reg;
  logic [31:0] pending_next;
  logic [31:0] event_bits;
  logic frozen_reg;
  logic [31:0] fault_code;
  logic [31:0] fault_addr;
  logic [31:0] rdata_next;
  logic ev_any;
  pser_pkg::pser_state_e state_next;

  // Map event pulses onto status bit positions
  always_comb begin
    event_bits = 32'h00000000;
    event_bits[pser_pkg::BIT_PARITY] = ev.parity_err;
    event_bits[pser_pkg::BIT_SHM] = ev.shm_err;
    event_bits[pser_pkg::BIT_SELFTEST] = ev.selftest_err;
    event_bits[pser_pkg::BIT_MAINT] = ev.parity_err | ev.shm_err | ev.selftest_err;
    event_bits[pser_pkg::BIT_OTHER] = ev.other_err;
    event_bits[pser_pkg::BIT_TIMER] = ev.timer_expired;
    event_bits[pser_pkg::BIT_RAM] = ev.ram_err;
    event_bits[pser_pkg::BIT_STRUCT] = ev.struct_err;
    event_bits[pser_pkg::BIT_INIT] = ev.init_done;
    event_bits[pser_pkg::BIT_DISABLE] = ev.disable_done;
    event_bits[pser_pkg::BIT_POOL] = ev.pool_empty;
    event_bits[pser_pkg::BIT_REPLY] = ev.reply_ready;
    event_bits = event_bits & pser_pkg::STATUS_MASK;
  end

  assign ev_any = |event_bits;

  // Visible status and events held back while it is frozen
  always_comb begin
    status_next = status_reg;
    pending_next = pending_reg;
    if (status_release) begin
      // Release hands the register back; held and same-cycle events survive
      status_next = pending_reg | event_bits;
      pending_next = 32'h00000000;
    end else if (frozen_reg) begin
      pending_next = pending_reg | event_bits;
    end else begin
      status_next = status_reg | event_bits;
    end
  end

  // CPU writes never reach the status register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= pser_pkg::STATUS_RST;
      pending_reg <= pser_pkg::STATUS_RST;
    end else begin
      status_reg <= status_next & pser_pkg::STATUS_MASK;
      pending_reg <= pending_next & pser_pkg::STATUS_MASK;
    end
  end

  // Freeze once an interrupt is requested
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frozen_reg <= 1'b0;
    end else if (status_release) begin
      frozen_reg <= irq_enable & ((|pending_reg) | ev_any);
    end else if (!frozen_reg && irq_enable && ev_any) begin
      frozen_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_irq <= 1'b0;
    end else begin
      status_irq <= irq_enable & (frozen_reg | (ev_any & !frozen_reg)) & !status_release;
    end
  end

  // Port state; stopping faults outrank progress events
  always_comb begin
    state_next = port_state;
    if (ev.parity_err | ev.shm_err | ev.selftest_err) begin
      state_next = pser_pkg::PSER_UNINIT;
    end else if (ev.timer_expired) begin
      state_next = pser_pkg::PSER_UNINIT_MAINT;
    end else if (ev.other_err) begin
      state_next = pser_pkg::PSER_DISABLED_MAINT;
    end else if (ev.ram_err | ev.struct_err | ev.init_done | ev.disable_done) begin
      state_next = maint_mode ? pser_pkg::PSER_DISABLED_MAINT
                              : pser_pkg::PSER_DISABLED;
    end else if (ev.enable_done) begin
      state_next = maint_mode ? pser_pkg::PSER_ENABLED_MAINT : pser_pkg::PSER_ENABLED;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      port_state <= pser_pkg::PSER_UNINIT;
    end else begin
      port_state <= state_next;
    end
  end

  // Queue structure faults leave the queues locked until reinitialized
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      queues_locked <= 1'b0;
    end else if (ev.struct_err && ev.struct_in_queue) begin
      queues_locked <= 1'b1;
    end else if (ev.init_done) begin
      queues_locked <= 1'b0;
    end
  end

  pser_fault_capture u_capture (
    .core_clk(core_clk),
    .rstn(rstn),
    .ev(ev),
    .fault_code_reg(fault_code),
    .fault_addr_reg(fault_addr)
  );

  // Read decode; writes are accepted and ignored
  always_comb begin
    rdata_next = pser_pkg::RDATA_IDLE;
    if (cpu_req.rd && !chip_init) begin
      case (cpu_req.addr)
        pser_pkg::ADDR_STATUS: begin
          rdata_next = status_reg & pser_pkg::STATUS_MASK;
        end
        pser_pkg::ADDR_FAULT_CODE: begin
          rdata_next = fault_code;
        end
        pser_pkg::ADDR_FAULT_ADDR: begin
          rdata_next = fault_addr;
        end
        default: begin
          rdata_next = pser_pkg::RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= pser_pkg::RDATA_IDLE;
      cpu_ack <= 1'b0;
    end else begin
      cpu_rdata <= rdata_next;
      cpu_ack <= cpu_req.rd | cpu_req.wr;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/pser_pkg.sv ====
// Shared constants, types and register map for the port status and error report bank
`default_nettype none
package pser_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'h2000404C;
  localparam logic [31:0] ADDR_FAULT_CODE = 32'h20004050;
  localparam logic [31:0] ADDR_FAULT_ADDR = 32'h20004054;

  // Reset values
  localparam logic [31:0] STATUS_RST = 32'h00000000;
  localparam logic [31:0] CODE_RST = 32'h00000000;
  localparam logic [31:0] FADDR_RST = 32'h00000000;
  localparam logic [31:0] RDATA_IDLE = 32'h00000000;

  // Status bit positions
  localparam int BIT_MAINT = 31;
  localparam int BIT_SELFTEST = 19;
  localparam int BIT_PARITY = 17;
  localparam int BIT_SHM = 16;
  localparam int BIT_OTHER = 7;
  localparam int BIT_TIMER = 6;
  localparam int BIT_RAM = 5;
  localparam int BIT_STRUCT = 4;
  localparam int BIT_INIT = 3;
  localparam int BIT_DISABLE = 2;
  localparam int BIT_POOL = 1;
  localparam int BIT_REPLY = 0;

  // Bits that can ever read as one
  localparam logic [31:0] STATUS_MASK = 32'h800B00FF;

  // Fault code field positions
  localparam int CODE_MOD_LSB = 24;
  localparam int CODE_SPEC_LSB = 16;
  localparam int CODE_STRUCT_LSB = 0;

  typedef enum logic [2:0] {
    PSER_UNINIT = 3'b000,
    PSER_UNINIT_MAINT = 3'b001,
    PSER_DISABLED = 3'b010,
    PSER_DISABLED_MAINT = 3'b011,
    PSER_ENABLED = 3'b100,
    PSER_ENABLED_MAINT = 3'b101
  } pser_state_e;

  // One-cycle event pulses from the port engine, with their data
  typedef struct packed {
    logic parity_err;
    logic shm_err;
    logic selftest_err;
    logic other_err;
    logic timer_expired;
    logic ram_err;
    logic struct_err;
    logic struct_in_queue;
    logic init_done;
    logic disable_done;
    logic enable_done;
    logic pool_empty;
    logic reply_ready;
    logic buf_mem_err;
    logic [7:0] other_module;
    logic [7:0] other_specific;
    logic [15:0] struct_number;
    logic [31:0] fail_addr;
  } pser_event_s;

  // CPU register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pser_cpu_req_s;

endpackage

`default_nettype wire

// ==== verilog/pser_fault_capture.sv ====
// Fault code and failing address capture with lock after stopping faults
`timescale 1ns/1ps
`default_nettype none

module pser_fault_capture (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Events
  input wire pser_pkg::pser_event_s ev,
  // Captured values
  output logic [31:0] fault_code_reg,
  output logic [31:0] fault_addr_reg
);

  logic stopped_reg;
  logic fatal;
  logic code_upper;

  assign fatal = ev.parity_err | ev.shm_err | ev.selftest_err | ev.timer_expired |
                 ev.ram_err | ev.struct_err | ev.other_err;
  assign code_upper = ev.other_err | ev.selftest_err;

  // Once stopped, later errors do not disturb the captured values
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stopped_reg <= 1'b0;
    end else if (fatal) begin
      stopped_reg <= 1'b1;
    end else if (ev.init_done) begin
      stopped_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_code_reg <= pser_pkg::CODE_RST;
    end else if (!stopped_reg) begin
      if (code_upper) begin
        fault_code_reg[pser_pkg::CODE_MOD_LSB +: 8] <= ev.other_module;
        fault_code_reg[pser_pkg::CODE_SPEC_LSB +: 8] <= ev.other_specific;
      end
      if (ev.struct_err) begin
        fault_code_reg[pser_pkg::CODE_STRUCT_LSB +: 16] <= ev.struct_number;
      end
    end
  end

  // Buffer errors overwrite until a stopping fault; stopping faults other than timer expiry and miscellaneous errors capture once
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fault_addr_reg <= pser_pkg::FADDR_RST;
    end else if (!stopped_reg && (ev.struct_err | ev.ram_err | ev.parity_err | ev.shm_err |
                                  ev.selftest_err | ev.buf_mem_err)) begin
      fault_addr_reg <= ev.fail_addr;
    end
  end

endmodule

`default_nettype wire

// ==== bench/pser_port_status_asserts.sv ====
// Concurrent checks on the ports of the port status bank
`timescale 1ns/1ps
`default_nettype none
module pser_port_status_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // CPU register access
  input wire pser_pkg::pser_cpu_req_s cpu_req,
  input wire logic [31:0] cpu_rdata,
  input wire logic cpu_ack,
  // Events and modes
  input wire pser_pkg::pser_event_s ev,
  input wire logic maint_mode,
  input wire logic chip_init,
  input wire logic status_release,
  input wire logic irq_enable,
  // Results
  input wire logic status_irq,
  input wire logic queues_locked,
  input wire pser_pkg::pser_state_e port_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic uninit_fault;
  logic dis_event;
  assign uninit_fault = ev.parity_err | ev.shm_err | ev.selftest_err;
  assign dis_event = ev.init_done | ev.disable_done | ev.ram_err | ev.struct_err;
  sequence s_req;
    cpu_req.rd || cpu_req.wr;
  endsequence
  sequence s_status_read;
    (cpu_req.rd && cpu_req.addr == pser_pkg::ADDR_STATUS && !chip_init) ##1 cpu_ack;
  endsequence
  a_ack_follows: assert property (s_req |=> cpu_ack)
    else $error("no acknowledge after an access");
  a_ack_cause: assert property (cpu_ack |-> $past(cpu_req.rd || cpu_req.wr))
    else $error("acknowledge without an access");
  a_rdata_idle: assert property (!cpu_ack |-> cpu_rdata == 32'h00000000)
    else $error("read data outside acknowledge");
  a_status_mbz: assert property (s_status_read |->
    (cpu_rdata & ~pser_pkg::STATUS_MASK) == 32'h00000000)
    else $error("reserved status bits read nonzero");
  a_init_read: assert property (cpu_req.rd && chip_init |=> cpu_rdata == 32'h00000000)
    else $error("read during chip init not zero");
  a_uninit_fault: assert property (uninit_fault |=> port_state == pser_pkg::PSER_UNINIT)
    else $error("port not uninitialized after fault");
  a_timer_state: assert property (ev.timer_expired && !uninit_fault
    |=> port_state == pser_pkg::PSER_UNINIT_MAINT)
    else $error("timer expiry state wrong");
  a_other_state: assert property (ev.other_err && !uninit_fault && !ev.timer_expired
    |=> port_state == pser_pkg::PSER_DISABLED_MAINT)
    else $error("miscellaneous error state wrong");
  a_disabled_state: assert property (dis_event && !uninit_fault && !ev.timer_expired
    && !ev.other_err |=> port_state == ($past(maint_mode) ? pser_pkg::PSER_DISABLED_MAINT
    : pser_pkg::PSER_DISABLED))
    else $error("disabled state wrong");
  a_queue_lock: assert property (ev.struct_err && ev.struct_in_queue |=> queues_locked)
    else $error("queues not locked");
  a_irq_hold: assert property (status_irq && !status_release |=> status_irq)
    else $error("interrupt dropped before release");
endmodule
bind pser_port_status pser_port_status_asserts i_chk (.core_clk(core_clk), .rstn(rstn),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .ev(ev),
  .maint_mode(maint_mode), .chip_init(chip_init), .status_release(status_release),
  .irq_enable(irq_enable), .status_irq(status_irq), .queues_locked(queues_locked),
  .port_state(port_state));
`default_nettype wire

// ==== bench/pser_port_status_tb.sv ====
// Self-checking bench for the port status and error report bank
`timescale 1ns/1ps
`default_nettype none
module pser_port_status_tb;
  logic core_clk;
  logic rstn;
  pser_pkg::pser_cpu_req_s cpu_req;
  pser_pkg::pser_event_s ev;
  logic maint_mode, chip_init, status_release, irq_enable;
  logic cpu_ack, status_irq, queues_locked;
  logic [31:0] cpu_rdata, rd_val, exp_addr, exp_code, a, b, r;
  pser_pkg::pser_state_e port_state;
  int fails;
  int samples_checked;
  // Expected status per event kind
  logic [31:0] mask_tab [11] = '{32'h00000001, 32'h00000002, 32'h00000008, 32'h00000004,
    32'h00000010, 32'h00000020, 32'h00000040, 32'h00000080, 32'h80010000, 32'h80020000,
    32'h80080000};
  // Event flags in the order of mask_tab; last entry is the buffer memory error
  logic [13:0] fl_tab [12] = '{14'h0002, 14'h0004, 14'h0020, 14'h0010, 14'h00C0, 14'h0100,
    14'h0200, 14'h0400, 14'h1000, 14'h2000, 14'h0800, 14'h0001};
  pser_port_status i_dut (.core_clk(core_clk), .rstn(rstn), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .ev(ev), .maint_mode(maint_mode),
    .chip_init(chip_init), .status_release(status_release), .irq_enable(irq_enable),
    .status_irq(status_irq), .queues_locked(queues_locked), .port_state(port_state));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic pser_pkg::pser_event_s mk(input int k);
    return pser_pkg::pser_event_s'({fl_tab[k], r, a});
  endfunction
  function automatic pser_pkg::pser_state_e st(input int k, input logic m);
    if (k >= 8) return pser_pkg::PSER_UNINIT;
    if (k == 6) return pser_pkg::PSER_UNINIT_MAINT;
    if (k == 7 || m) return pser_pkg::PSER_DISABLED_MAINT;
    return pser_pkg::PSER_DISABLED;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] ad);
    @(posedge core_clk) #1;
    cpu_req = '{!wr, wr, ad, 32'hFFFFFFFF};
    @(posedge core_clk) #1;
    cpu_req = '0;
    rd_val = cpu_rdata;
  endtask
  task automatic pulse(input pser_pkg::pser_event_s e, input logic rel);
    @(posedge core_clk) #1;
    ev = e;
    status_release = rel;
    @(posedge core_clk) #1;
    ev = '0;
    status_release = 1'b0;
  endtask
  task automatic results;
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    results();
  end
  initial begin
    rstn = 1'b0;
    cpu_req = '0;
    ev = '0;
    {maint_mode, chip_init, status_release, irq_enable} = 4'h0;
    {exp_addr, exp_code, a, r} = '0;
    void'($urandom(32'h77A6090F));
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, pser_pkg::ADDR_STATUS + 32'(4 * i));
      chk(rd_val, 32'h00000000);
    end
    $display("test reset done");
    for (int k = 0; k < 11; k++) begin
      maint_mode = 1'($urandom_range(1));
      pulse('0, 1'b1);
      pulse(mk(2), 1'b0);
      pulse('0, 1'b1);
      a = $urandom;
      r = $urandom;
      b = $urandom;
      pulse(mk(k), 1'b0);
      if (k >= 4 && k != 6 && k != 7) exp_addr = a;
      if (k == 4) exp_code[15:0] = r[15:0];
      if (k == 7 || k == 10) exp_code[31:16] = r[31:16];
      chk({29'h0, port_state}, {29'h0, st(k, maint_mode)});
      if (k == 4) chk({31'h0, queues_locked}, 32'h00000001);
      bus(1'b1, pser_pkg::ADDR_STATUS);
      bus(1'b0, pser_pkg::ADDR_STATUS);
      chk(rd_val, mask_tab[k]);
      bus(1'b0, pser_pkg::ADDR_FAULT_CODE);
      chk(rd_val, exp_code);
      a = b;
      pulse(mk(11), 1'b0);
      if (k < 4) exp_addr = b;
      bus(1'b0, pser_pkg::ADDR_FAULT_ADDR);
      chk(rd_val, exp_addr);
      $display("test event %0d done", k);
    end
    chip_init = 1'b1;
    bus(1'b0, pser_pkg::ADDR_FAULT_ADDR);
    chk(rd_val, 32'h00000000);
    chip_init = 1'b0;
    // Structure fault outside a queue must not lock the queues
    pulse(mk(2), 1'b0);
    pulse(pser_pkg::pser_event_s'({14'h0080, r, a}), 1'b0);
    chk({31'h0, queues_locked}, 32'h00000000);
    pulse(mk(2), 1'b0);
    pulse(pser_pkg::pser_event_s'({14'h0008, r, a}), 1'b0);
    chk({29'h0, port_state}, {29'h0, maint_mode ? pser_pkg::PSER_ENABLED_MAINT
      : pser_pkg::PSER_ENABLED});
    pulse(mk(3), 1'b0);
    chk({29'h0, port_state}, {29'h0, st(3, maint_mode)});
    // Event in the release cycle survives the release
    pulse(mk(0), 1'b1);
    bus(1'b0, pser_pkg::ADDR_STATUS);
    chk(rd_val, 32'h00000001);
    pulse('0, 1'b1);
    $display("test corner done");
    irq_enable = 1'b1;
    pulse('0, 1'b1);
    pulse(mk(0), 1'b0);
    chk({31'h0, status_irq}, 32'h00000001);
    pulse(mk(1), 1'b0);
    bus(1'b0, pser_pkg::ADDR_STATUS);
    chk(rd_val, 32'h00000001);
    pulse('0, 1'b1);
    bus(1'b0, pser_pkg::ADDR_STATUS);
    chk(rd_val, 32'h00000002);
    chk({31'h0, status_irq}, 32'h00000001);
    pulse('0, 1'b1);
    bus(1'b0, pser_pkg::ADDR_STATUS);
    chk(rd_val, 32'h00000000);
    chk({31'h0, status_irq}, 32'h00000000);
    $display("test interrupt done");
    // Reset in mid-run drops a pending interrupt and the status
    pulse(mk(3), 1'b0);
    chk({31'h0, status_irq}, 32'h00000001);
    @(posedge core_clk) #1 rstn = 1'b0;
    @(posedge core_clk) #1 rstn = 1'b1;
    chk({31'h0, status_irq}, 32'h00000000);
    bus(1'b0, pser_pkg::ADDR_STATUS);
    chk(rd_val, 32'h00000000);
    $display("test reset again done");
    results();
  end
endmodule
`default_nettype wire
